// ===== srom_autoload.sv
/*
 * Configuration ROM auto-loader: reads the whole serial ROM after reset, checks
 * the identity block, fills configuration registers, decodes controller 0 and
 * drives the wake and PME pins. Assumes a classic Wishbone master and
 * single-cycle wake event pulses synchronous to mclk.
 */
// Overview of operation
// RULE1: Wake pin active high when loaded bit 4 clear, active low when set.
// RULE2: Wake pin pulses when loaded bit 6 clear, holds a level when set.
// RULE3: New-capabilities byte bit 0 drives bit 20 of the command/status word.
// RULE4: Power capability byte bits 7..3 land in power register bits 31..27.
// RULE5: Power capability byte bits 2..0 land in power register bits 21..19.
// RULE6: Power control bit 3 keeps the PME pin undriven.
// RULE7: Power control bit 2 keeps the wake pin undriven.
// RULE8: Power control bit 1 makes a link change a wake event.
// RULE9: Power control bit 0 makes a directed wake packet a wake event.
// RULE10: Checksum at byte 16 is checked over the identity block.
// RULE11: With ID loading off, built-in vendor and device IDs are shown.
// RULE12: The ROM holds format version 03 at byte 18.
// RULE13: Byte 19 counts controllers, each with its own information block.
// RULE14: Controller header: node address, controller number, body pointer.
// RULE15: Body byte 2 sets direction of each general-purpose port pin.
// RULE16: Block types: 01 PHY, 00 media, 80 delay period.
// RULE17: Delay block carries a two-byte microsecond time unit at offset 2.
// RULE18: PHY capability and advertisement fields use standard autoneg bits.
// RULE19: Vendor and device IDs load only when auto-load bits 3..0 are 1010.
// RULE20: Capability and power fields load only when bits 7..4 match 1X1X.
// RULE21: A checksum failure suppresses loading of identification values.
// RULE22: Loaded values are returned on reads only after the load finishes. Status register reads are answered at once, even mid-load.
`timescale 1ns/10ps
module srom_autoload (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic srom_cs,
    output logic srom_sk,
    output logic srom_di,
    input wire logic srom_do,
    input wire logic link_change_evt,
    input wire logic magic_pkt_evt,
    output logic wake_output_pin_o,
    output logic wake_output_pin_oe,
    output logic pme_o,
    output logic pme_oe,
    output logic [7:0] general_purpose_port_dir,
    output logic load_done
);
    import srom_pkg::*;

    typedef enum {S_READ, S_WAIT, S_CRC, S_HDR, S_BLK, S_DONE} load_state_e;

    srom_if rq ();
    load_state_e state_q;
    logic [7:0] rom [0:ROM_BYTES-1];
    logic [6:0] idx_q;
    logic [7:0] crc_q;
    logic [7:0] blk_left_q;
    logic [6:0] ptr_q;
    logic crc_ok_q;
    logic [15:0] vendor_q, device_q, sub_vendor_q, sub_device_q;
    logic new_cap_q;
    logic [7:0] pmc_q, pwr_ctl_q, wake_cfg_q;
    logic [7:0] version_q, ctrl_count_q, ctrl_num_q, phy_num_q, media_mask_q;
    logic [15:0] media_cap_q, nway_adv_q, delay_unit_q;
    logic wake_event_q, pme_en_q;
    logic [7:0] pulse_cnt_q;
    logic [7:0] blk_type, blk_len, gi, ri;
    logic [6:0] cap_at;
    logic evt;
    logic [31:0] rd_data;

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
        end
        return r;
    endfunction : crc8

    srom_reader u_reader (
        .mclk(mclk),
        .reset(reset),
        .ce(ce),
        .rq(rq.reader),
        .cs_q(srom_cs),
        .sk_q(srom_sk),
        .di_q(srom_di),
        .dout(srom_do)
    );

    // ************************************************************
    // Block walker decode
    // ************************************************************
    always_comb begin
        blk_len = {1'b0, rom[ptr_q][6:0]};
        blk_type = rom[7'(ptr_q + 7'd1)];
        gi = rom[7'(ptr_q + 7'd3)];
        ri = rom[7'(ptr_q + 7'd4 + gi[6:0])];
        cap_at = 7'(ptr_q + 7'd5 + gi[6:0] + ri[6:0]);
    end

    // ************************************************************
    // Load sequence
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q <= S_READ;
            idx_q <= 7'h00;
            crc_q <= 8'h00;
            ptr_q <= 7'h00;
            blk_left_q <= 8'h00;
            rq.start <= 1'b0;
            rq.addr <= 6'h00;
        end else if (ce) begin
            rq.start <= 1'b0;
            case (state_q)
                S_READ: begin
                    rq.start <= 1'b1;
                    rq.addr <= idx_q[5:0];
                    state_q <= S_WAIT;
                end
                S_WAIT: begin
                    if (rq.done) begin
                        rom[{idx_q[5:0], 1'b0}] <= rq.word[7:0];
                        rom[{idx_q[5:0], 1'b1}] <= rq.word[15:8];
                        idx_q <= idx_q + 7'd1;
                        state_q <= (idx_q == 7'(ROM_WORDS - 1)) ? S_CRC : S_READ;
                        if (idx_q == 7'(ROM_WORDS - 1)) begin
                            idx_q <= 7'h00;
                        end
                    end
                end
                S_CRC: begin
                    crc_q <= crc8(crc_q, rom[idx_q]); // [RULE10]
                    idx_q <= idx_q + 7'd1;
                    if (idx_q == OFS_ID_CRC - 7'd1) begin
                        state_q <= S_HDR;
                    end
                end
                S_HDR: begin
                    // Only controller 0 is decoded; others are left to the driver
                    ptr_q <= 7'(rom[OFS_CTRL0_HDR + HDR_BODY_PTR] + BODY_FIRST_BLK); // [RULE14]
                    blk_left_q <= rom[7'(rom[OFS_CTRL0_HDR + HDR_BODY_PTR] + BODY_BLK_COUNT)];
                    state_q <= S_BLK;
                end
                S_BLK: begin
                    if (blk_left_q == 8'h00 || blk_len == 8'h00) begin
                        state_q <= S_DONE;
                    end else begin
                        blk_left_q <= blk_left_q - 8'd1;
                        ptr_q <= 7'(ptr_q + blk_len[6:0] + 7'd1);
                    end
                end
                S_DONE: begin
                    state_q <= S_DONE;
                end
                default: begin
                    state_q <= S_READ;
                end
            endcase
        end
    end

    // ************************************************************
    // Configuration values
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            crc_ok_q <= 1'b0;
            vendor_q <= DEF_VENDOR_ID;
            device_q <= DEF_DEVICE_ID;
            sub_vendor_q <= 16'h0000;
            sub_device_q <= 16'h0000;
            new_cap_q <= 1'b0;
            pmc_q <= 8'h00;
            pwr_ctl_q <= 8'h00;
            wake_cfg_q <= 8'h00;
            version_q <= 8'h00;
            ctrl_count_q <= 8'h00;
            ctrl_num_q <= 8'h00;
            general_purpose_port_dir <= 8'h00;
        end else if (ce && state_q == S_HDR) begin
            crc_ok_q <= (crc_q == rom[OFS_ID_CRC]); // [RULE10]
            version_q <= rom[OFS_VERSION];
            ctrl_count_q <= rom[OFS_CTRL_COUNT];
            ctrl_num_q <= rom[OFS_CTRL0_HDR + HDR_CTRL_NUM]; // [RULE14]
            general_purpose_port_dir <=
                rom[7'(rom[OFS_CTRL0_HDR + HDR_BODY_PTR] + BODY_GP_CTRL)]; // [RULE15]
            if (crc_q == rom[OFS_ID_CRC]) begin // [RULE21]
                sub_vendor_q <= {rom[OFS_SUB_VENDOR + 7'd1], rom[OFS_SUB_VENDOR]};
                sub_device_q <= {rom[OFS_SUB_DEVICE + 7'd1], rom[OFS_SUB_DEVICE]};
                if (rom[OFS_AUTOLOAD][3:0] == ID_LOAD_KEY) begin // [RULE19] [RULE11]
                    vendor_q <= {rom[OFS_VENDOR + 7'd1], rom[OFS_VENDOR]};
                    device_q <= {rom[OFS_DEVICE + 7'd1], rom[OFS_DEVICE]};
                end
            end
            if (rom[OFS_AUTOLOAD][7] && rom[OFS_AUTOLOAD][5]) begin // [RULE20]
                new_cap_q <= rom[OFS_NEWCAP][0]; // [RULE3]
                pmc_q <= rom[OFS_PMC];
                pwr_ctl_q <= rom[OFS_PWRCTL];
                wake_cfg_q <= rom[OFS_AUTOLOAD];
            end
        end
    end

    // ************************************************************
    // Information block decode
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            phy_num_q <= 8'h00;
            media_cap_q <= 16'h0000;
            nway_adv_q <= 16'h0000;
            delay_unit_q <= 16'h0000;
            media_mask_q <= 8'h00;
        end else if (ce && state_q == S_BLK && blk_left_q != 8'h00 && blk_len != 8'h00) begin
            case (blk_type) // [RULE16]
                BLK_TYPE_PHY: begin
                    phy_num_q <= rom[7'(ptr_q + 7'd2)];
                    // Kept in autonegotiation register bit order [RULE18]
                    media_cap_q <= {rom[cap_at], rom[7'(cap_at + 7'd1)]};
                    nway_adv_q <= {rom[7'(cap_at + 7'd2)], rom[7'(cap_at + 7'd3)]};
                end
                BLK_TYPE_MEDIA: begin
                    media_mask_q[rom[7'(ptr_q + 7'd2)][2:0]] <= 1'b1;
                end
                BLK_TYPE_DELAY: begin
                    delay_unit_q <= {rom[7'(ptr_q + 7'd2)], rom[7'(ptr_q + 7'd3)]}; // [RULE17]
                end
                default: begin
                    delay_unit_q <= delay_unit_q;
                end
            endcase
        end
    end

    // ************************************************************
    // Wake and PME logic
    // ************************************************************
    assign evt = load_done && ((link_change_evt && pwr_ctl_q[1]) // [RULE8]
        || (magic_pkt_evt && pwr_ctl_q[0])); // [RULE9]

    always_ff @(posedge mclk) begin
        if (reset) begin
            wake_event_q <= 1'b0;
            pme_en_q <= 1'b0;
            pulse_cnt_q <= 8'h00;
        end else if (ce) begin
            if (wb_ack_o && wb_we_i && wb_adr_i == REG_WAKE && wb_sel_i[1]) begin
                pme_en_q <= wb_dat_i[8];
            end
            // A new event wins over a software clear in the same cycle
            if (evt) begin
                wake_event_q <= 1'b1;
            end else if (wb_ack_o && wb_we_i && wb_adr_i == REG_WAKE && wb_sel_i[0]
                         && wb_dat_i[0]) begin
                wake_event_q <= 1'b0;
            end
            if (evt) begin
                pulse_cnt_q <= 8'(WAKE_PULSE_CYC);
            end else if (pulse_cnt_q != 8'h00) begin
                pulse_cnt_q <= pulse_cnt_q - 8'd1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            wake_output_pin_o <= 1'b0;
            wake_output_pin_oe <= 1'b0;
            pme_o <= 1'b0;
            pme_oe <= 1'b0;
        end else if (ce) begin
            wake_output_pin_o <= (wake_cfg_q[6] ? wake_event_q : (pulse_cnt_q != 8'h00)) // [RULE2]
                ^ wake_cfg_q[4]; // [RULE1]
            wake_output_pin_oe <= load_done && !pwr_ctl_q[2]; // [RULE7]
            pme_o <= 1'b0;
            pme_oe <= wake_event_q && pme_en_q && !pwr_ctl_q[3]; // [RULE6]
        end
    end

    // ************************************************************
    // Wishbone slave
    // ************************************************************
    always_comb begin
        case (wb_adr_i)
            REG_ID: rd_data = {device_q, vendor_q};
            REG_SUBSYS: rd_data = {sub_device_q, sub_vendor_q};
            REG_CMDSTAT: rd_data = {11'h000, new_cap_q, 20'h00000}; // [RULE3]
            REG_PMR: rd_data = {pmc_q[7:3], 5'h00, pmc_q[2:0], 11'h000, pwr_ctl_q}; // [RULE4] [RULE5]
            REG_STATUS: rd_data = {ctrl_num_q, ctrl_count_q, version_q, 6'h00, crc_ok_q, load_done};
            REG_PHY: rd_data = {nway_adv_q, media_cap_q};
            REG_MEDIA: rd_data = {delay_unit_q, media_mask_q, phy_num_q};
            REG_WAKE: rd_data = {23'h000000, pme_en_q, 7'h00, wake_event_q};
            default: rd_data = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            load_done <= 1'b0;
        end else if (ce) begin
            load_done <= (state_q == S_DONE);
            wb_ack_o <= 1'b0;
            // Requests other than status wait for the load to finish [RULE22]
            if (wb_cyc_i && wb_stb_i && !wb_ack_o && (load_done || wb_adr_i == REG_STATUS)) begin
                wb_ack_o <= 1'b1;
                wb_dat_o <= rd_data;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    AST_POLARITY: assert property (@(posedge mclk) disable iff (reset) // [RULE1]
        ce && !wake_cfg_q[6] && pulse_cnt_q == 8'h00 |=> wake_output_pin_o == $past(wake_cfg_q[4]))
        else $error("wake idle level wrong");
    AST_LEVEL: assert property (@(posedge mclk) disable iff (reset) // [RULE2]
        ce && wake_cfg_q[6] |=> wake_output_pin_o == ($past(wake_event_q) ^ $past(wake_cfg_q[4])))
        else $error("wake level mode wrong");
    AST_NEWCAP: assert property (@(posedge mclk) disable iff (reset) // [RULE3]
        wb_ack_o && wb_adr_i == REG_CMDSTAT && !wb_we_i |-> wb_dat_o[20] == new_cap_q)
        else $error("new capability bit misplaced");
    AST_PME_OFF: assert property (@(posedge mclk) disable iff (reset) // [RULE6]
        pwr_ctl_q[3] && $stable(pwr_ctl_q) |-> !pme_oe)
        else $error("PME driven while disabled");
    AST_WAKE_OFF: assert property (@(posedge mclk) disable iff (reset) // [RULE7]
        ce && pwr_ctl_q[2] |=> !wake_output_pin_oe)
        else $error("wake pin driven while disabled");
    AST_LINK_EVT: assert property (@(posedge mclk) disable iff (reset) // [RULE8]
        ce && load_done && link_change_evt && pwr_ctl_q[1] |=> wake_event_q)
        else $error("link change not latched");
    AST_MAGIC_EVT: assert property (@(posedge mclk) disable iff (reset) // [RULE9]
        ce && load_done && magic_pkt_evt && pwr_ctl_q[0] |=> wake_event_q)
        else $error("wake packet not latched");
    AST_ID_DEFAULT: assert property (@(posedge mclk) disable iff (reset) // [RULE21]
        load_done && !crc_ok_q |-> vendor_q == DEF_VENDOR_ID && device_q == DEF_DEVICE_ID)
        else $error("ID loaded despite checksum failure");
    AST_READ_WAIT: assert property (@(posedge mclk) disable iff (reset) // [RULE22]
        wb_ack_o && wb_adr_i != REG_STATUS |-> $past(load_done))
        else $error("config read answered before load");
endmodule : srom_autoload

// ===== srom_pkg.sv
/*
 * Constants for the serial configuration ROM loader: ROM layout, register map,
 * reset values and timing. Assumes a 100 MHz mclk and a 64-word serial ROM.
 */
package srom_pkg;
    // ************************************************************
    // ROM layout (byte offsets)
    // ************************************************************
    localparam int ROM_WORDS = 64;
    localparam int ROM_BYTES = 128;
    localparam logic [6:0] OFS_SUB_VENDOR = 7'h00;
    localparam logic [6:0] OFS_SUB_DEVICE = 7'h02;
    localparam logic [6:0] OFS_AUTOLOAD = 7'h08;
    localparam logic [6:0] OFS_NEWCAP = 7'h09;
    localparam logic [6:0] OFS_VENDOR = 7'h0A;
    localparam logic [6:0] OFS_DEVICE = 7'h0C;
    localparam logic [6:0] OFS_PMC = 7'h0E;
    localparam logic [6:0] OFS_PWRCTL = 7'h0F;
    localparam logic [6:0] OFS_ID_CRC = 7'h10;
    localparam logic [6:0] OFS_VERSION = 7'h12;
    localparam logic [6:0] OFS_CTRL_COUNT = 7'h13;
    localparam logic [6:0] OFS_CTRL0_HDR = 7'h14;
    localparam logic [6:0] HDR_CTRL_NUM = 7'h06;
    localparam logic [6:0] HDR_BODY_PTR = 7'h07;
    localparam logic [6:0] BODY_GP_CTRL = 7'h02;
    localparam logic [6:0] BODY_BLK_COUNT = 7'h03;
    localparam logic [6:0] BODY_FIRST_BLK = 7'h04;
    localparam logic [7:0] BLK_TYPE_MEDIA = 8'h00;
    localparam logic [7:0] BLK_TYPE_PHY = 8'h01;
    localparam logic [7:0] BLK_TYPE_DELAY = 8'h80;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [3:0] ID_LOAD_KEY = 4'hA;
    // ************************************************************
    // Built-in identity (values arbitrary)
    // ************************************************************
    localparam logic [15:0] DEF_VENDOR_ID = 16'hABCD;
    localparam logic [15:0] DEF_DEVICE_ID = 16'h0001;
    // ************************************************************
    // Register map (byte addresses on the bus)
    // ************************************************************
    localparam logic [7:0] REG_ID = 8'h00;
    localparam logic [7:0] REG_SUBSYS = 8'h04;
    localparam logic [7:0] REG_CMDSTAT = 8'h08;
    localparam logic [7:0] REG_PMR = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_PHY = 8'h14;
    localparam logic [7:0] REG_MEDIA = 8'h18;
    localparam logic [7:0] REG_WAKE = 8'h1C;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ = 100;
    localparam int SK_HALF_NS = 100;
    localparam int SK_HALF_CYC = (SK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_PULSE_NS = 500;
    localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS * CLK_MHZ) / 1000;
    localparam int SROM_BITS = 26;
endpackage : srom_pkg

// ===== srom_if.sv
/*
 * Word-read handshake between the loader and the serial ROM reader.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface srom_if;
    logic start;
    logic [5:0] addr;
    logic busy;
    logic done;
    logic [15:0] word;
    modport loader (output start, output addr, input busy, input done, input word);
    modport reader (input start, input addr, output busy, output done, output word);
endinterface : srom_if

// ===== srom_reader.sv
/*
 * Serial ROM word reader: start bit, read opcode, six address bits, then a dummy
 * bit and sixteen data bits, MSB first. Assumes a 93-series style serial ROM.
 */
`timescale 1ns/10ps
module srom_reader (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    srom_if.reader rq,
    output logic cs_q,
    output logic sk_q,
    output logic di_q,
    input wire logic dout
);
    import srom_pkg::*;
    logic [9:0] div_q;
    logic [4:0] bit_q;
    logic [7:0] cmd_q;
    logic [15:0] shift_q;

    // ************************************************************
    // Bit sequencer
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            cs_q <= 1'b0;
            sk_q <= 1'b0;
            di_q <= 1'b0;
            div_q <= 10'h000;
            bit_q <= 5'h00;
            cmd_q <= 8'h00;
            shift_q <= 16'h0000;
            rq.busy <= 1'b0;
            rq.done <= 1'b0;
            rq.word <= 16'h0000;
        end else if (ce) begin
            rq.done <= 1'b0;
            if (!rq.busy) begin
                if (rq.start) begin
                    rq.busy <= 1'b1;
                    cs_q <= 1'b1;
                    // Start bit goes out with chip select, a half period ahead of SK
                    di_q <= 1'b1;
                    cmd_q <= {2'b10, rq.addr};
                    bit_q <= 5'h00;
                    div_q <= 10'h000;
                end
            end else if (div_q == 10'(SK_HALF_CYC - 1)) begin
                div_q <= 10'h000;
                if (!sk_q) begin
                    sk_q <= 1'b1;
                end else begin
                    sk_q <= 1'b0;
                    // Next bit changes on the falling edge, so it is settled when SK rises
                    di_q <= (bit_q < 5'd8) ? cmd_q[7] : 1'b0;
                    if (bit_q < 5'd8) begin
                        cmd_q <= {cmd_q[6:0], 1'b0};
                    end
                    if (bit_q >= 5'd10) begin
                        shift_q <= {shift_q[14:0], dout};
                    end
                    if (bit_q == 5'(SROM_BITS - 1)) begin
                        rq.busy <= 1'b0;
                        rq.done <= 1'b1;
                        rq.word <= {shift_q[14:0], dout};
                        cs_q <= 1'b0;
                        di_q <= 1'b0;
                    end
                    bit_q <= bit_q + 5'd1;
                end
            end else begin
                div_q <= div_q + 10'd1;
            end
        end
    end
endmodule : srom_reader

// ===== srom_model.sv
/* Serial configuration ROM model, 93-series style, read command only.
   Assumes one word per chip-select frame and sk far slower than mclk. */
`timescale 1ns/10ps
module srom_model (
    input wire logic mclk,
    input wire logic cs,
    input wire logic sk,
    input wire logic di,
    output logic dout
);
    logic [7:0] mem [0:127];
    logic [5:0] adr_q;
    logic sk_q;
    logic di_q;
    int n_q = 0;
    initial dout = 1'b0;
    always @(posedge mclk) begin
        sk_q <= sk;
        if (sk) di_q <= di;
        if (!cs) begin
            // Released line toggles so a stale bit cannot pass for data
            n_q <= 0;
            dout <= ~dout;
        end else if (!sk && sk_q) begin
            n_q <= n_q + 1;
            if (n_q >= 3 && n_q <= 8) adr_q <= {adr_q[4:0], di_q};
        end else if (sk && !sk_q && n_q >= 9) begin
            dout <= (n_q == 9) ? 1'b0 : mem[{adr_q, 1'(n_q < 18)}][7 - ((n_q - 10) % 8)];
        end
    end
endmodule : srom_model

// ===== serial_rom_config_autoload_test.sv
/* Testbench for the ROM auto-loader: a clean load and a load with a bad checksum.
   Assumes the ROM model answers every read; run spans two complete loads. */
`timescale 1ns/10ps
module serial_rom_config_autoload_test;
    import srom_pkg::*;
    logic mclk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, lnk = 1'b0, mgc = 1'b0;
    logic [7:0] adr = 8'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat, rd;
    logic ack, cs, sk, di, dout, wo, woe, po, poe, done;
    logic [7:0] gpd;
    int err_total = 0, n_compared = 0;
    localparam logic [7:0] IMG [0:54] = '{8'h21, 8'h43, 8'h65, 8'h87, 8'h0, 8'h0, 8'h0,
        8'h0, 8'hBA, 8'h01, 8'h57, 8'h13, 8'h68, 8'h24, 8'hCD, 8'h03, 8'h0, 8'h0, 8'h03,
        8'h01, 8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h0, 8'h1E, 8'h0, 8'h0, 8'h0,
        8'h08, 8'h5A, 8'h03, 8'h8A, 8'h01, 8'h05, 8'h0, 8'h0, 8'h78, 8'h0, 8'h01, 8'hE0,
        8'h50, 8'h0, 8'h83, 8'h80, 8'h20, 8'h20,
        8'h85, 8'h00, 8'h04, 8'h0, 8'h87, 8'h0};
    always #5 mclk = ~mclk;
    srom_autoload i_srom_autoload (.mclk(mclk), .reset(reset), .ce(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .srom_cs(cs), .srom_sk(sk), .srom_di(di),
        .srom_do(dout), .link_change_evt(lnk), .magic_pkt_evt(mgc), .wake_output_pin_o(wo),
        .wake_output_pin_oe(woe), .pme_o(po), .pme_oe(poe), .general_purpose_port_dir(gpd),
        .load_done(done));
    srom_model i_srom_model (.mclk(mclk), .cs(cs), .sk(sk), .di(di), .dout(dout));
    task automatic tally_and_finish();
        if (err_total == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                       input logic [31:0] d);
        int n;
        @(posedge mclk);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
        for (n = 0; n < 40000; n++) begin
            @(posedge mclk);
            if (ack === 1'b1) break;
        end
        rd = rdat;
        if (n == 40000) begin
            err_total++;
            tally_and_finish();
        end
        {cyc, stb} <= 2'b00;
    endtask : bus
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        bus(1'b0, a, 4'hF, 32'h0);
        cmp(rd & m, e);
    endtask : rd_chk
    task automatic pulse(input logic magic);
        @(posedge mclk);
        {mgc, lnk} <= {magic, ~magic};
        @(posedge mclk);
        {mgc, lnk} <= 2'b00;
    endtask : pulse
    function automatic logic [7:0] crc8();
        logic [7:0] c;
        c = 8'h0;
        for (int i = 0; i < 16; i++) begin
            c = c ^ i_srom_model.mem[i];
            for (int b = 0; b < 8; b++) c = c[7] ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
        end
        return c;
    endfunction : crc8
    initial begin
        for (int i = 0; i < 128; i++) i_srom_model.mem[i] = (i < 55) ? IMG[i] : 8'h0;
        i_srom_model.mem[16] = crc8();
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        pulse(1'b1);
        rd_chk(REG_STATUS, 32'h0, 32'h1);
        rd_chk(REG_ID, 32'h2468_1357, 32'hFFFF_FFFF);
        cmp({31'h0, done}, 32'h1);
        rd_chk(REG_SUBSYS, 32'h8765_4321, 32'hFFFF_FFFF);
        rd_chk(REG_CMDSTAT, 32'h0010_0000, 32'h0010_0000);
        rd_chk(REG_PMR, 32'hC828_0003, 32'hF838_00FF);
        rd_chk(REG_STATUS, 32'h0001_0303, 32'hFFFF_FFFF);
        rd_chk(REG_PHY, 32'h01E0_7800, 32'hFFFF_FFFF);
        rd_chk(REG_MEDIA, 32'h2020_1005, 32'hFFFF_FFFF);
        cmp({24'h0, gpd}, 32'h5A);
        rd_chk(REG_WAKE, 32'h0, 32'h1);
        bus(1'b1, REG_WAKE, 4'h2, 32'h100);
        pulse(1'b1);
        repeat (3) @(posedge mclk);
        cmp({29'h0, woe, wo, poe}, 32'h5);
        repeat (60) @(posedge mclk);
        cmp({31'h0, woe & ~wo}, 32'h0);
        rd_chk(REG_WAKE, 32'h1, 32'h1);
        bus(1'b1, REG_WAKE, 4'h1, 32'h1);
        rd_chk(REG_WAKE, 32'h0, 32'h1);
        cmp({30'h0, poe, po}, 32'h0);
        pulse(1'b0);
        repeat (3) @(posedge mclk);
        rd_chk(REG_WAKE, 32'h1, 32'h1);
        rd_chk(8'h20, 32'h0, 32'hFFFF_FFFF);
        // Second load: level mode, active high, pins disabled, checksum broken
        @(posedge mclk);
        reset <= 1'b1;
        i_srom_model.mem[8] = 8'hEA;
        i_srom_model.mem[15] = 8'h0F;
        i_srom_model.mem[16] = ~crc8();
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        rd_chk(REG_ID, {DEF_DEVICE_ID, DEF_VENDOR_ID}, 32'hFFFF_FFFF);
        rd_chk(REG_SUBSYS, 32'h0, 32'hFFFF_FFFF);
        rd_chk(REG_STATUS, 32'h0001_0301, 32'hFFFF_FFFF);
        bus(1'b1, REG_WAKE, 4'h2, 32'h100);
        pulse(1'b1);
        repeat (3) @(posedge mclk);
        cmp({29'h0, woe, wo, poe}, 32'h2);
        repeat (60) @(posedge mclk);
        cmp({31'h0, wo}, 32'h1);
        tally_and_finish();
    end
endmodule : serial_rom_config_autoload_test
